// File: rtl/tg_ram_pkg.sv
// Package: field layouts, reset values and carriers for the telegram RAM parser
package tg_ram_pkg;

  // ************************************************************
  // Container word 0 and header word 0 fields
  // ************************************************************
  localparam int LEN_LSB      = 0;
  localparam int LEN_W        = 10;
  localparam int SVC_USE_BIT  = 10;
  localparam int SVC_IDX_LSB  = 11;
  localparam int SVC_IDX_W    = 3;
  localparam int ROLE_BIT     = 14;
  localparam int FINAL_BIT    = 15;
  localparam int HDR_DMA_BIT  = 8;
  localparam int HDR_TWIN_BUFFER_SELECT_BIT = 9;
  localparam int END_MK_LO    = 14;
  localparam int END_MK_HI    = 15;
  localparam int CONT_CTRL_WORDS = 2;

  // ************************************************************
  // Service container layout
  // ************************************************************
  localparam int SC_CTRL_WORDS  = 5;
  localparam int SC_BUF_MAX     = 255;
  localparam int W0_HS          = 0;
  localparam int W0_RW          = 1;
  localparam int W0_END         = 2;
  localparam int W0_ELEM_LSB    = 3;
  localparam int W0_REQUEST_END_FLAG      = 6;
  localparam int W0_BUSY        = 7;
  localparam int W0_NINFO_LSB   = 8;
  localparam int W0_INT_ERR     = 12;
  localparam int W0_INT_WR      = 13;
  localparam int W0_INT_RD      = 14;
  localparam int W1_LAST_TRANSFER_FAULT      = 7;
  localparam int W4_SRC_BIT     = 8;
  localparam int W4_PROTO       = 9;
  localparam int W4_HS_TO       = 10;
  localparam int W4_BUSY_TO     = 11;
  localparam int W4_CMD         = 12;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [7:0]  TALLY_RESET = 8'h00;
  localparam logic [7:0]  TALLY_MAX   = 8'hFF;

  // ************************************************************
  // FIFO
  // ************************************************************
  localparam int FIFO_W = 16;
  localparam int FIFO_D = 8;

  // Decoded container word 0 and 1
  typedef struct packed {
    logic       final_container_flag;
    logic       service_role_select;
    logic [2:0] service_box_index;
    logic       uses_service_box;
    logic [9:0] block_word_count;
    logic [15:0] position;
  } container_s;

  // Incoming service bits from the answer telegram
  typedef struct packed {
    logic incoming_handshake_bit;
    logic incoming_busy_bit;
    logic incoming_error_bit;
    logic incoming_command_change_bit;
  } at_bits_s;

  typedef enum logic [2:0] {
    ST_IDLE, ST_W0, ST_W1, ST_DATA, ST_ENDT, ST_DONE
  } walk_e;

endpackage

// File: rtl/tg_fifo.sv
// The data FIFO module is defined alongside the walker logic

// File: rtl/telegram_ram_container_parser.sv
// Telegram RAM walker: data containers, end marker and master service container
`timescale 1ns/1ps
module telegram_ram_container_parser
  import tg_ram_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  // Walk control from the telegram engine
  input  wire logic        i_walk_start,
  input  wire logic [15:0] i_header_word0,
  input  wire logic        i_is_receive,
  // RAM read stream, words in address order
  input  wire logic        i_ram_valid,
  input  wire logic [15:0] i_ram_word,
  output logic             o_ram_ready,
  // Data word stream out
  output logic             o_data_valid,
  output logic [15:0]      o_data_word,
  input  wire logic        i_data_ready,
  // Decoded container
  output container_s       o_container,
  output logic             o_container_valid,
  output logic             o_walk_done,
  output logic             o_end_marker_seen,
  output logic [15:0]      o_cycle_finish_time,
  // Service container, host side
  input  wire logic        i_host_wr,
  input  wire logic [2:0]  i_host_idx,
  input  wire logic [15:0] i_host_data,
  // Service container, engine side events
  input  wire logic        i_at_valid,
  input  wire at_bits_s    i_at_bits,
  input  wire logic        i_at_fault,
  input  wire logic        i_mdt_sent,
  input  wire logic        i_wr_advance,
  input  wire logic        i_rd_advance,
  input  wire logic        i_proto_fault,
  input  wire logic        i_hs_timeout,
  input  wire logic        i_busy_timeout,
  input  wire logic        i_host_ack,
  // Service container word image
  output logic [15:0]      o_sc_word0,
  output logic [15:0]      o_sc_word1,
  output logic [15:0]      o_sc_word2,
  output logic [15:0]      o_sc_word3,
  output logic [15:0]      o_sc_word4,
  output logic [2:0]       o_outgoing_element_type,
  output logic             o_outgoing_end_bit
);

  // ************************************************************
  // Walker
  // ************************************************************
  walk_e       state_r;
  logic [10:0] data_left_r;
  logic [15:0] w0_r;
  logic        dma_r;
  logic        twin_r;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [15:0] fifo_out_data;
  logic        last_seen_r;

  // Number of buffer words following the control words
  function automatic logic [10:0] buf_words(input logic [9:0] len,
                                             input logic dma, input logic twin);
    if (dma)
      buf_words = 11'h000;
    else if (twin)
      buf_words = {len, 1'b0};
    else
      buf_words = {1'b0, len};
  endfunction

  // Ready: walk running and FIFO room; lags one cycle, so it only paces the source
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      o_ram_ready <= 1'b0;
    else
      o_ram_ready <= (state_r != ST_IDLE) && (state_r != ST_DONE) && fifo_in_ready;
  end

  // State sequencing over the container chain
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_r     <= ST_IDLE;
      data_left_r <= 11'h000;
      w0_r        <= WORD_RESET;
      dma_r       <= 1'b0;
      twin_r      <= 1'b0;
      last_seen_r <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
          if (i_walk_start)
          begin
            dma_r   <= i_header_word0[HDR_DMA_BIT];
            twin_r  <= i_header_word0[HDR_TWIN_BUFFER_SELECT_BIT];
            last_seen_r <= 1'b0;
            state_r <= ST_W0;
          end
        ST_W0:
          if (i_ram_valid)
          begin
            w0_r <= i_ram_word;
            if (i_ram_word[END_MK_HI] && i_ram_word[END_MK_LO])
              state_r <= ST_ENDT;
            else
              state_r <= last_seen_r ? ST_DONE : ST_W1;      // Header after final ends walk
          end
        ST_W1:
          if (i_ram_valid)
          begin
            data_left_r <= buf_words(w0_r[LEN_LSB +: LEN_W], dma_r, twin_r);
            state_r     <= (buf_words(w0_r[LEN_LSB +: LEN_W], dma_r, twin_r) == 11'h000)
                           ? ST_W0 : ST_DATA;
            last_seen_r <= w0_r[FINAL_BIT];
          end
        ST_DATA:
          if (i_ram_valid && fifo_in_ready)
          begin
            data_left_r <= data_left_r - 11'h001;
            if (data_left_r == 11'h001)
              state_r <= ST_W0;                              // Next container word 0 or end marker read next
          end
        ST_ENDT:
          if (i_ram_valid)
            state_r <= ST_DONE;
        ST_DONE:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // Decoded container outputs, published when word 1 arrives
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_container       <= '0;
      o_container_valid <= 1'b0;
    end
    else
    begin
      o_container_valid <= (state_r == ST_W1) && i_ram_valid;
      if ((state_r == ST_W1) && i_ram_valid)
      begin
        o_container.block_word_count     <= w0_r[LEN_LSB +: LEN_W];
        o_container.uses_service_box     <= w0_r[SVC_USE_BIT];
        o_container.service_box_index    <= w0_r[SVC_IDX_LSB +: SVC_IDX_W];
        o_container.service_role_select  <= w0_r[ROLE_BIT];
        o_container.final_container_flag <= w0_r[FINAL_BIT];
        o_container.position <= i_is_receive ? i_ram_word : WORD_RESET;
      end
    end
  end

  // End marker and walk completion
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_end_marker_seen   <= 1'b0;
      o_cycle_finish_time <= WORD_RESET;
      o_walk_done         <= 1'b0;
    end
    else
    begin
      o_walk_done <= (state_r == ST_DONE);
      if (i_walk_start && state_r == ST_IDLE)
        o_end_marker_seen <= 1'b0;
      else if ((state_r == ST_ENDT) && i_ram_valid)
      begin
        o_end_marker_seen   <= 1'b1;
        o_cycle_finish_time <= i_ram_word;
      end
    end
  end

  tg_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_rst       (i_rst),
    .i_in_valid  ((state_r == ST_DATA) && i_ram_valid),
    .i_in_data   (i_ram_word),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (fifo_out_valid),
    .o_out_data  (fifo_out_data),
    .i_out_ready (i_data_ready && !(o_data_valid && !i_data_ready))
  );

  // Output register stage after the FIFO
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_data_valid <= 1'b0;
      o_data_word  <= WORD_RESET;
    end
    else if (!o_data_valid || i_data_ready)
    begin
      o_data_valid <= fifo_out_valid && i_data_ready;
      o_data_word  <= fifo_out_data;
    end
  end

  // ************************************************************
  // Master-mode service container
  // ************************************************************
  logic [15:0] sc0_r;
  logic [15:0] sc1_r;
  logic [15:0] sc2_r;
  logic [15:0] sc3_r;
  logic [15:0] sc4_r;

  // Host writes the words; hardware events win over a host clear
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      sc0_r <= WORD_RESET;
      sc1_r <= WORD_RESET;
      sc2_r <= WORD_RESET;
      sc3_r <= WORD_RESET;
      sc4_r <= WORD_RESET;
    end
    else
    begin
      if (i_host_wr)
        unique case (i_host_idx)
          3'h0: sc0_r <= i_host_data;
          3'h1: sc1_r <= i_host_data;
          3'h2: sc2_r <= i_host_data;
          3'h3: sc3_r <= i_host_data;
          3'h4: sc4_r <= i_host_data;
          default: ;
        endcase
      // Busy flag: set when a transfer completes, cleared by host ack
      if (i_host_ack)
        sc0_r[W0_BUSY] <= 1'b0;
      if (i_at_valid || i_mdt_sent)
        sc0_r[W0_BUSY] <= 1'b1;
      if (i_mdt_sent && sc0_r[W0_REQUEST_END_FLAG])
        sc0_r[W0_END] <= 1'b1;
      if (i_at_valid && i_at_bits.incoming_error_bit)
        sc0_r[W0_INT_ERR] <= 1'b1;
      if (i_wr_advance && sc2_r[7:0] == sc2_r[15:8])
        sc0_r[W0_INT_WR] <= 1'b1;
      if (i_rd_advance && sc3_r[7:0] == sc3_r[15:8])
        sc0_r[W0_INT_RD] <= 1'b1;
      if (i_at_valid)
      begin
        sc1_r[3:0] <= {i_at_bits.incoming_command_change_bit,
                       i_at_bits.incoming_error_bit,
                       i_at_bits.incoming_busy_bit,
                       i_at_bits.incoming_handshake_bit};
        sc1_r[6:4] <= 3'h0;
        sc1_r[W1_LAST_TRANSFER_FAULT] <= i_at_fault;
      end
      // Cursors advance until they reach the last position
      if (i_wr_advance && sc2_r[7:0] != sc2_r[15:8])
        sc2_r[7:0] <= sc2_r[7:0] + 8'h01;
      if (i_rd_advance && sc3_r[7:0] != sc3_r[15:8])
        sc3_r[7:0] <= sc3_r[7:0] + 8'h01;
      // Tally saturates rather than wrapping to keep faults visible
      if (i_at_valid && sc4_r[7:0] != TALLY_MAX &&
          (sc4_r[W4_SRC_BIT] ? i_at_bits.incoming_busy_bit
                             : (i_at_bits.incoming_handshake_bit != sc0_r[W0_HS])))
        sc4_r[7:0] <= sc4_r[7:0] + 8'h01;
      if (i_proto_fault)
        sc4_r[W4_PROTO] <= 1'b1;
      if (i_hs_timeout)
        sc4_r[W4_HS_TO] <= 1'b1;
      if (i_busy_timeout)
        sc4_r[W4_BUSY_TO] <= 1'b1;
      if (i_at_valid && i_at_bits.incoming_command_change_bit)
        sc4_r[W4_CMD] <= 1'b1;
    end
  end

  // Registered word image; unused bits read as zero
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_sc_word0 <= WORD_RESET;
      o_sc_word1 <= WORD_RESET;
      o_sc_word2 <= WORD_RESET;
      o_sc_word3 <= WORD_RESET;
      o_sc_word4 <= WORD_RESET;
      o_outgoing_element_type <= 3'h0;
      o_outgoing_end_bit      <= 1'b0;
    end
    else
    begin
      o_sc_word0 <= sc0_r & 16'h73FF;
      o_sc_word1 <= sc1_r & 16'h038F;
      o_sc_word2 <= sc2_r;
      o_sc_word3 <= sc3_r;
      o_sc_word4 <= sc4_r & 16'h1FFF;
      o_outgoing_element_type <= sc0_r[W0_ELEM_LSB +: 3];
      o_outgoing_end_bit      <= sc0_r[W0_END];
    end
  end

endmodule // telegram_ram_container_parser

// ************************************************************
// Data FIFO
// ************************************************************
module tg_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  // Fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Drain side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);

  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  // Handshakes; full and empty come straight from the fill count
  assign o_in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_r != '0);
  assign o_out_data  = mem[rd_r];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // Storage array, no reset needed on data
  always_ff @(posedge i_clk_sys)
  begin
    if (push)
      mem[wr_r] <= i_in_data;
  end

  // Pointers wrap at DEPTH
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
      if (pop)
        rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule // tg_fifo

// File: tb/tg_parser_chk.sv
// Checker: timing of service word image and walk pulses of the parser
`timescale 1ns/1ps
module tg_parser_chk
  import tg_ram_pkg::*;
(
  // Clock and reset
  input wire logic       i_clk_sys,
  input wire logic       i_rst,
  // Events and host access
  input wire logic       i_host_wr,
  input wire logic       i_at_valid,
  input wire at_bits_s   i_at_bits,
  input wire logic       i_at_fault,
  input wire logic       i_mdt_sent,
  input wire logic       i_host_ack,
  input wire logic       i_proto_fault,
  input wire logic       i_hs_timeout,
  // Observed outputs
  input wire logic [15:0] o_sc_word0,
  input wire logic [15:0] o_sc_word1,
  input wire logic [15:0] o_sc_word4,
  input wire logic       o_walk_done,
  input wire logic       o_container_valid
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  // Image lags state by one cycle, so the check looks two cycles on; host writes are kept out of the event cycle and the next
  sequence s_calm(ev);
    ev && !i_host_wr ##1 !i_host_wr;
  endsequence

  property p_busy_set;
    s_calm(i_at_valid || i_mdt_sent) |=> o_sc_word0[W0_BUSY];
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy not set");
  property p_busy_clr;
    s_calm(i_host_ack && !i_at_valid && !i_mdt_sent) |=> !o_sc_word0[W0_BUSY];
  endproperty
  a_busy_clr: assert property (p_busy_clr) else $error("busy not cleared");
  property p_at_copy;
    s_calm(i_at_valid) |=> o_sc_word1[3:0] == {$past(i_at_bits.incoming_command_change_bit, 2),
      $past(i_at_bits.incoming_error_bit, 2), $past(i_at_bits.incoming_busy_bit, 2),
      $past(i_at_bits.incoming_handshake_bit, 2)};
  endproperty
  a_at_copy: assert property (p_at_copy) else $error("incoming bits wrong");
  property p_fault;
    s_calm(i_at_valid) |=> o_sc_word1[W1_LAST_TRANSFER_FAULT] == $past(i_at_fault, 2);
  endproperty
  a_fault: assert property (p_fault) else $error("transfer fault bit wrong");
  property p_slave_err;
    s_calm(i_at_valid && i_at_bits.incoming_error_bit) |=> o_sc_word0[W0_INT_ERR];
  endproperty
  a_slave_err: assert property (p_slave_err) else $error("slave error event lost");
  property p_cmd;
    s_calm(i_at_valid && i_at_bits.incoming_command_change_bit) |=> o_sc_word4[W4_CMD];
  endproperty
  a_cmd: assert property (p_cmd) else $error("command change event lost");
  property p_proto;
    s_calm(i_proto_fault) |=> o_sc_word4[W4_PROTO];
  endproperty
  a_proto: assert property (p_proto) else $error("protocol event lost");
  property p_hs_to;
    s_calm(i_hs_timeout) |=> o_sc_word4[W4_HS_TO];
  endproperty
  a_hs_to: assert property (p_hs_to) else $error("handshake timeout lost");
  property p_tally;
    s_calm(o_sc_word4[7:0] == TALLY_MAX && !$past(i_host_wr)) |=> o_sc_word4[7:0] == TALLY_MAX;
  endproperty
  a_tally: assert property (p_tally) else $error("tally wrapped");
  property p_pulses;
    (o_walk_done || o_container_valid) |=> !o_walk_done && !o_container_valid;
  endproperty
  a_pulses: assert property (p_pulses) else $error("pulse too long");
endmodule // tg_parser_chk

bind telegram_ram_container_parser tg_parser_chk u_chk (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_host_wr(i_host_wr), .i_at_valid(i_at_valid),
  .i_at_bits(i_at_bits), .i_at_fault(i_at_fault), .i_mdt_sent(i_mdt_sent),
  .i_host_ack(i_host_ack), .i_proto_fault(i_proto_fault), .i_hs_timeout(i_hs_timeout),
  .o_sc_word0(o_sc_word0), .o_sc_word1(o_sc_word1), .o_sc_word4(o_sc_word4),
  .o_walk_done(o_walk_done), .o_container_valid(o_container_valid));

// File: tb/tg_ram_model.sv
// Host RAM model: streams telegram words to the walker in address order
`timescale 1ns/1ps
module tg_ram_model (
  // Clock and reset
  input  wire logic   i_clk_sys,
  input  wire logic   i_rst,
  // Word stream
  output logic        o_ram_valid,
  output logic [15:0] o_ram_word
);
  logic [15:0] words_q[$];
  logic [15:0] last_r;

  task automatic push(input logic [15:0] w);
    words_q.push_back(w);
  endtask

  // One word per edge; an empty stream shows inverted data so stale words never pass
  always @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_ram_valid <= 1'b0;
      o_ram_word  <= 16'h0000;
      last_r      <= 16'h0000;
    end
    else if (words_q.size() != 0)
    begin
      o_ram_valid <= 1'b1;
      o_ram_word  <= words_q[0];
      last_r      <= words_q.pop_front();
    end
    else
    begin
      o_ram_valid <= 1'b0;
      o_ram_word  <= ~last_r;
    end
  end
endmodule // tg_ram_model

// File: tb/telegram_ram_container_parser_test.sv
// Testbench: container walks and master service container of the parser
`timescale 1ns/1ps
module telegram_ram_container_parser_test;
  import tg_ram_pkg::*;
  logic clk = 1'b0, rst = 1'b1, start = 1'b0, is_rx = 1'b0, hwr = 1'b0, fault = 1'b0;
  logic [15:0] hdr = 16'h0000, hdata = 16'h0000, word, dword, fin;
  logic [15:0] w0, w1, w2, w3, w4;
  logic [2:0]  hidx = 3'h0, elem;
  logic [7:0]  ev = 8'h00;
  logic        ready_seen;
  at_bits_s    atb = 4'h0;
  container_s  cont;
  logic rvalid, ready, dvalid, cvalid, done, endseen, endbit, done_seen, dma_v, twin_v, rx_v;
  logic [31:0] exp_c[$], got_c[$];
  logic [15:0] exp_d[$], got_d[$];
  int mismatches = 0, samples_checked = 0;

  always #2 clk = ~clk;

  tg_ram_model host (.i_clk_sys(clk), .i_rst(rst), .o_ram_valid(rvalid), .o_ram_word(word));

  telegram_ram_container_parser dut (
    .i_clk_sys(clk), .i_rst(rst), .i_walk_start(start), .i_header_word0(hdr),
    .i_is_receive(is_rx), .i_ram_valid(rvalid), .i_ram_word(word), .o_ram_ready(ready),
    .o_data_valid(dvalid), .o_data_word(dword), .i_data_ready(1'b1), .o_container(cont),
    .o_container_valid(cvalid), .o_walk_done(done), .o_end_marker_seen(endseen),
    .o_cycle_finish_time(fin), .i_host_wr(hwr), .i_host_idx(hidx), .i_host_data(hdata),
    .i_at_valid(ev[0]), .i_at_bits(atb), .i_at_fault(fault), .i_mdt_sent(ev[1]),
    .i_wr_advance(ev[2]), .i_rd_advance(ev[3]), .i_proto_fault(ev[4]),
    .i_hs_timeout(ev[5]), .i_busy_timeout(ev[6]), .i_host_ack(ev[7]),
    .o_sc_word0(w0), .o_sc_word1(w1), .o_sc_word2(w2), .o_sc_word3(w3), .o_sc_word4(w4),
    .o_outgoing_element_type(elem), .o_outgoing_end_bit(endbit));

  // Collect what the parser hands out
  always @(posedge clk)
  begin
    if (cvalid) got_c.push_back(cont);
    if (dvalid) got_d.push_back(dword);
    if (done) done_seen = 1'b1;
    if (ready) ready_seen = 1'b1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (mismatches == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ************************************************************
  // Walk helpers
  // ************************************************************
  task automatic begin_walk(input logic [15:0] h, input logic r);
    @(posedge clk);
    start <= 1'b1;
    hdr <= h;
    is_rx <= r;
    rx_v = r;
    dma_v = h[HDR_DMA_BIT];
    twin_v = h[HDR_TWIN_BUFFER_SELECT_BIT];
    done_seen = 1'b0;
    ready_seen = 1'b0;
    // Words are queued only after the start edge, so none reach an idle walker
    @(posedge clk);
    start <= 1'b0;
  endtask

  // Buffer words per container follow from the header mode
  task automatic add(input logic [15:0] c0, c1);
    int n;
    n = dma_v ? 0 : (twin_v ? 2 * c0[9:0] : c0[9:0]);
    host.push(c0);
    host.push(c1);
    exp_c.push_back({c0, rx_v ? c1 : 16'h0000});
    for (int i = 0; i < n; i++)
    begin
      host.push(c1 + 16'h1000 + 16'(i));
      exp_d.push_back(c1 + 16'h1000 + 16'(i));
    end
  endtask

  task automatic end_walk(input logic [15:0] em, input logic [15:0] tf);
    host.push(em);
    host.push(tf);
    for (int i = 0; i < 300 && !done_seen; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    chk(done_seen, 1'b1);
    chk(ready_seen, 1'b1);
    chk(ready, 1'b0);
    chk(got_c.size(), exp_c.size());
    foreach (exp_c[i]) chk(got_c[i], exp_c[i]);
    chk(got_d.size(), exp_d.size());
    foreach (exp_d[i]) chk(got_d[i], exp_d[i]);
    chk(endseen, 1'b1);
    chk(fin, tf);
    exp_c.delete(); got_c.delete(); exp_d.delete(); got_d.delete();
  endtask

  // ************************************************************
  // Service container helpers
  // ************************************************************
  task automatic hw(input logic [2:0] idx, input logic [15:0] d);
    @(posedge clk);
    hwr <= 1'b1;
    hidx <= idx;
    hdata <= d;
    @(posedge clk);
    hwr <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Bits: 0 answer, 1 sent, 2 wr adv, 3 rd adv, 4 proto, 5 hs to, 6 busy to, 7 ack
  task automatic pulse(input logic [7:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 8'h00;
    repeat (3) @(posedge clk);
  endtask

  initial
  begin
    #40000;
    mismatches++;
    give_verdict();
  end

  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk({w0, w4}, {WORD_RESET, WORD_RESET});
    begin_walk(16'h0000, 1'b1);
    add(16'h6C03, 16'h0000);
    add(16'h8002, 16'h0003);
    end_walk(16'hC000, 16'h1234);
    begin_walk(16'h0200, 1'b0);
    add(16'h8002, 16'h0055);
    end_walk(16'hC000, 16'h00AB);
    begin_walk(16'h0100, 1'b1);
    add(16'h8005, 16'h0007);
    end_walk(16'hFFFF, 16'hBEEF);
    hw(3'h0, 16'h0269);
    chk(w0, 16'h0269);
    chk(elem, 3'h5);
    hw(3'h1, 16'h0300);
    chk(w1, 16'h0300);
    pulse(8'h02);
    chk(w0, 16'h02ED);
    chk(endbit, 1'b1);
    pulse(8'h80);
    chk(w0, 16'h026D);
    atb <= 4'b1011;
    fault <= 1'b1;
    pulse(8'h01);
    chk({w0, w1, w4}, {16'h12ED, 16'h038D, 16'h1000});
    atb <= 4'b0000;
    fault <= 1'b0;
    pulse(8'h01);
    chk({w1, w4}, {16'h0300, 16'h1001});
    hw(3'h4, 16'h00FE);
    repeat (3) pulse(8'h01);
    chk(w4, 16'h00FF);
    hw(3'h2, 16'h0200);
    pulse(8'h04);
    chk(w2, 16'h0201);
    repeat (2) pulse(8'h04);
    chk({w2, 15'h0000, w0[W0_INT_WR]}, {16'h0202, 16'h0001});
    hw(3'h3, 16'h0100);
    repeat (2) pulse(8'h08);
    chk({w3, 15'h0000, w0[W0_INT_RD]}, {16'h0101, 16'h0001});
    pulse(8'h70);
    chk(w4, 16'h0EFF);
    hw(3'h5, 16'hFFFF);
    chk(w4, 16'h0EFF);
    give_verdict();
  end
endmodule // telegram_ram_container_parser_test
